//--- dsar_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsar_params.svh"
module dsar_regs #(
   parameter logic [31:0] DEB_UNIT_CYC = `DSAR_DEB_UNIT_CYC,
   parameter logic [31:0] POP_SHORT_CYC = `DSAR_POP_SHORT_CYC,
   parameter logic [31:0] POP_LONG_CYC = `DSAR_POP_LONG_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register port from the serial interface decoder
   input wire logic [3:0] reg_page,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // Driver power-down levels from the analog drivers
   input wire logic speaker_driver_a_off,
   input wire logic speaker_driver_b_off,
   input wire logic handset_receiver_driver_off,
   input wire logic virtual_ground_driver_off,
   input wire logic loudspeaker_driver_off,
   input wire logic cellphone_output_driver_off,
   // Pop sequencing
   input wire logic pop_start,
   output logic pop_sequence_bypass,
   output logic pop_duration_select,
   output logic pop_active,
   // AGC limits
   output logic [6:0] mic_gain_max_half_db,
   output logic [31:0] mic_to_silence_cyc,
   output logic [31:0] mic_from_silence_cyc,
   output logic [7:0] cell_gain_max_half_db,
   output logic cell_gain_invalid,
   output logic [31:0] cell_to_silence_cyc,
   output logic [31:0] cell_from_silence_cyc
);
   function automatic logic hit(input logic [3:0] pg, input logic [5:0] ad, input logic [5:0] ofs);
      hit = (pg == `DSAR_PAGE) && (ad == ofs);
   endfunction : hit

   // Two-stage synchronisers for the driver flags
   logic [5:0] flag_raw;
   logic [5:0] flag_s1_r, flag_s2_r;
   assign flag_raw = {speaker_driver_a_off, speaker_driver_b_off, handset_receiver_driver_off,
                      virtual_ground_driver_off, loudspeaker_driver_off, cellphone_output_driver_off};

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flag_s1_r <= `DSAR_FLAGS_RST;
         flag_s2_r <= `DSAR_FLAGS_RST;
      end else begin
         flag_s1_r <= flag_raw;
         flag_s2_r <= flag_s1_r;
      end
   end

   // Writable fields
   logic bypass_r, bypass_nxt, dur_r, dur_nxt;
   logic [6:0] mic_ceil_r, mic_ceil_nxt, cell_ceil_r, cell_ceil_nxt;
   logic [2:0] mic_ns_r, mic_ns_nxt, mic_sn_r, mic_sn_nxt;
   logic [15:0] rdata_nxt;

   always_comb begin
      bypass_nxt = bypass_r;
      dur_nxt = dur_r;
      mic_ceil_nxt = mic_ceil_r;
      mic_ns_nxt = mic_ns_r;
      mic_sn_nxt = mic_sn_r;
      cell_ceil_nxt = cell_ceil_r;
      if (reg_wr && hit(reg_page, reg_addr, `DSAR_OFS_STATUS)) begin
         bypass_nxt = reg_wdata[`DSAR_BIT_BYPASS];
         dur_nxt = reg_wdata[`DSAR_BIT_DUR];
      end
      if (reg_wr && hit(reg_page, reg_addr, `DSAR_OFS_MIC)) begin
         mic_ceil_nxt = reg_wdata[`DSAR_CEIL_HI:`DSAR_CEIL_LO];
         mic_ns_nxt = reg_wdata[`DSAR_NS_HI:`DSAR_NS_LO];
         mic_sn_nxt = reg_wdata[`DSAR_SN_HI:`DSAR_SN_LO];
      end
      if (reg_wr && hit(reg_page, reg_addr, `DSAR_OFS_CELL)) begin
         cell_ceil_nxt = reg_wdata[`DSAR_CEIL_HI:`DSAR_CEIL_LO];
      end
      // Reserved fields read as zero; cell debounce fields are read-only
      rdata_nxt = 16'h0000;
      if (hit(reg_page, reg_addr, `DSAR_OFS_STATUS)) begin
         rdata_nxt[`DSAR_BIT_FLAG_HI:`DSAR_BIT_FLAG_LO] = flag_s2_r;
         rdata_nxt[`DSAR_BIT_BYPASS] = bypass_r;
         rdata_nxt[`DSAR_BIT_DUR] = dur_r;
      end else if (hit(reg_page, reg_addr, `DSAR_OFS_MIC)) begin
         rdata_nxt[`DSAR_CEIL_HI:`DSAR_CEIL_LO] = mic_ceil_r;
         rdata_nxt[`DSAR_NS_HI:`DSAR_NS_LO] = mic_ns_r;
         rdata_nxt[`DSAR_SN_HI:`DSAR_SN_LO] = mic_sn_r;
      end else if (hit(reg_page, reg_addr, `DSAR_OFS_CELL)) begin
         rdata_nxt[`DSAR_CEIL_HI:`DSAR_CEIL_LO] = cell_ceil_r;
         rdata_nxt[`DSAR_NS_HI:`DSAR_NS_LO] = `DSAR_DEB_RST;
         rdata_nxt[`DSAR_SN_HI:`DSAR_SN_LO] = `DSAR_DEB_RST;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bypass_r <= 1'b0;
         dur_r <= 1'b0;
         mic_ceil_r <= `DSAR_CEIL_RST;
         mic_ns_r <= `DSAR_DEB_RST;
         mic_sn_r <= `DSAR_DEB_RST;
         cell_ceil_r <= `DSAR_CEIL_RST;
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         bypass_r <= bypass_nxt;
         dur_r <= dur_nxt;
         mic_ceil_r <= mic_ceil_nxt;
         mic_ns_r <= mic_ns_nxt;
         mic_sn_r <= mic_sn_nxt;
         cell_ceil_r <= cell_ceil_nxt;
         reg_rdata <= reg_rd ? rdata_nxt : reg_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   assign pop_sequence_bypass = bypass_r;
   assign pop_duration_select = dur_r;

   // Pop sequencing timer
   dsar_pkg::dsar_pop_state_type pop_state_r, pop_state_nxt;
   logic [31:0] pop_cnt_r, pop_cnt_nxt;

   always_comb begin
      pop_state_nxt = pop_state_r;
      pop_cnt_nxt = pop_cnt_r;
      case (pop_state_r)
         dsar_pkg::POP_IDLE: begin
            if (pop_start && !bypass_r) begin
               pop_state_nxt = dsar_pkg::POP_RUN;
               pop_cnt_nxt = (dur_r ? POP_LONG_CYC : POP_SHORT_CYC) - 32'h1;
            end
         end
         dsar_pkg::POP_RUN: begin
            if (bypass_r || pop_cnt_r == 32'h0) begin
               pop_state_nxt = dsar_pkg::POP_IDLE;
            end else begin
               pop_cnt_nxt = pop_cnt_r - 32'h1;
            end
         end
         default: begin
            pop_state_nxt = dsar_pkg::POP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pop_state_r <= dsar_pkg::POP_IDLE;
         pop_cnt_r <= 32'h0;
      end else begin
         pop_state_r <= pop_state_nxt;
         pop_cnt_r <= pop_cnt_nxt;
      end
   end

   assign pop_active = (pop_state_r == dsar_pkg::POP_RUN);

   dsar_lim_if lim ();
   assign lim.mic_ceiling = mic_ceil_r;
   assign lim.mic_ns = mic_ns_r;
   assign lim.mic_sn = mic_sn_r;
   assign lim.cell_ceiling = cell_ceil_r;
   assign lim.cell_ns = `DSAR_DEB_RST;
   assign lim.cell_sn = `DSAR_DEB_RST;

   dsar_limit_decode #(.DEB_UNIT_CYC(DEB_UNIT_CYC)) u_decode (
      .core_clk(core_clk),
      .resetn(resetn),
      .lim(lim),
      .mic_gain_max_half_db(mic_gain_max_half_db),
      .mic_to_silence_cyc(mic_to_silence_cyc),
      .mic_from_silence_cyc(mic_from_silence_cyc),
      .cell_gain_max_half_db(cell_gain_max_half_db),
      .cell_gain_invalid(cell_gain_invalid),
      .cell_to_silence_cyc(cell_to_silence_cyc),
      .cell_from_silence_cyc(cell_from_silence_cyc)
   );

   property p_spk_a_live;
      @(posedge core_clk) disable iff (!resetn)
      reg_rd && hit(reg_page, reg_addr, `DSAR_OFS_STATUS) |=> reg_rdata[15] == $past(flag_s2_r[5]);
   endproperty
   a_spk_a_live: assert property (p_spk_a_live) else $error("speaker A flag not live");

   property p_flags_follow;
      @(posedge core_clk) disable iff (!resetn)
      reg_rd && hit(reg_page, reg_addr, `DSAR_OFS_STATUS) |=> reg_rdata[14:10] == $past(flag_s2_r[4:0]);
   endproperty
   a_flags_follow: assert property (p_flags_follow) else $error("driver flags misplaced");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (!resetn)
      reg_rd && hit(reg_page, reg_addr, `DSAR_OFS_STATUS) |=> reg_rdata[9:6] == 4'h0 && reg_rdata[3:0] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_bypass_no_pop;
      @(posedge core_clk) disable iff (!resetn)
      bypass_r && !pop_active |=> !pop_active;
   endproperty
   a_bypass_no_pop: assert property (p_bypass_no_pop) else $error("pop ran while bypassed");

   property p_pop_starts;
      @(posedge core_clk) disable iff (!resetn)
      pop_start && !bypass_r && !pop_active |=> pop_active [*8];
   endproperty
   a_pop_starts: assert property (p_pop_starts) else $error("pop sequence did not run");

   property p_cell_deb_ro;
      @(posedge core_clk) disable iff (!resetn)
      reg_rd && hit(reg_page, reg_addr, `DSAR_OFS_CELL) |=> reg_rdata[8:0] == 9'h000;
   endproperty
   a_cell_deb_ro: assert property (p_cell_deb_ro) else $error("cell debounce not read-only");
endmodule : dsar_regs
`default_nettype wire

//--- dsar_params.svh
`ifndef DSAR_PARAMS_SVH
`define DSAR_PARAMS_SVH
`define DSAR_PAGE 4'h2
`define DSAR_OFS_STATUS 6'h25
`define DSAR_OFS_MIC 6'h26
`define DSAR_OFS_CELL 6'h27
`define DSAR_BIT_FLAG_HI 15
`define DSAR_BIT_FLAG_LO 10
`define DSAR_BIT_BYPASS 5
`define DSAR_BIT_DUR 4
`define DSAR_CEIL_HI 15
`define DSAR_CEIL_LO 9
`define DSAR_NS_HI 8
`define DSAR_NS_LO 6
`define DSAR_SN_HI 5
`define DSAR_SN_LO 3
`define DSAR_FLAGS_RST 6'h3F
`define DSAR_CEIL_RST 7'h7F
`define DSAR_DEB_RST 3'h0
`define DSAR_CLK_KHZ 10000
`define DSAR_DEB_UNIT_US 500
`define DSAR_DEB_UNIT_CYC ((`DSAR_DEB_UNIT_US * `DSAR_CLK_KHZ) / 1000)
`define DSAR_POP_SHORT_MS 802
`define DSAR_POP_LONG_MS 4006
`define DSAR_POP_SHORT_CYC (`DSAR_POP_SHORT_MS * `DSAR_CLK_KHZ)
`define DSAR_POP_LONG_CYC (`DSAR_POP_LONG_MS * `DSAR_CLK_KHZ)
`define DSAR_CELL_LAST_VALID 7'h44
`define DSAR_CELL_FIRST_TOP 7'h5E
`define DSAR_CELL_BASE_HALF_DB 8'hBB
`define DSAR_CELL_TOP_HALF_DB 8'h18
`endif

//--- dsar_pkg.sv
`default_nettype none
package dsar_pkg;
   typedef enum logic {
      POP_IDLE,
      POP_RUN
   } dsar_pop_state_type;
   typedef logic [15:0] dsar_word_type;
endpackage : dsar_pkg
`default_nettype wire

//--- dsar_lim_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsar_lim_if;
   logic [6:0] mic_ceiling;
   logic [2:0] mic_ns;
   logic [2:0] mic_sn;
   logic [6:0] cell_ceiling;
   logic [2:0] cell_ns;
   logic [2:0] cell_sn;
   modport src (output mic_ceiling, mic_ns, mic_sn, cell_ceiling, cell_ns, cell_sn);
   modport dec (input mic_ceiling, mic_ns, mic_sn, cell_ceiling, cell_ns, cell_sn);
endinterface : dsar_lim_if
`default_nettype wire

//--- dsar_limit_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsar_params.svh"
module dsar_limit_decode #(
   parameter logic [31:0] DEB_UNIT_CYC = `DSAR_DEB_UNIT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register fields
   dsar_lim_if.dec lim,
   // Decoded limits to the AGC loops
   output logic [6:0] mic_gain_max_half_db,
   output logic [31:0] mic_to_silence_cyc,
   output logic [31:0] mic_from_silence_cyc,
   output logic [7:0] cell_gain_max_half_db,
   output logic cell_gain_invalid,
   output logic [31:0] cell_to_silence_cyc,
   output logic [31:0] cell_from_silence_cyc
);
   // Ladder 0, 0.5, 1, 2 .. 32 ms in clock cycles
   function automatic logic [31:0] ladder(input logic [2:0] code);
      if (code == 3'h0) begin
         ladder = 32'h0;
      end else begin
         ladder = DEB_UNIT_CYC << (code - 3'h1);
      end
   endfunction : ladder

   logic [6:0] mic_gain_nxt;
   logic [31:0] mic_ns_nxt, mic_sn_nxt, cell_ns_nxt, cell_sn_nxt;
   logic [7:0] cell_gain_nxt;
   logic cell_inv_nxt;

   always_comb begin
      mic_gain_nxt = lim.mic_ceiling;
      mic_ns_nxt = ladder(lim.mic_ns);
      mic_sn_nxt = ladder(lim.mic_sn);
      cell_ns_nxt = ladder(lim.cell_ns);
      cell_sn_nxt = ladder(lim.cell_sn);
      cell_inv_nxt = 1'b0;
      if (lim.cell_ceiling <= `DSAR_CELL_LAST_VALID) begin
         cell_gain_nxt = `DSAR_CELL_BASE_HALF_DB + {1'b0, lim.cell_ceiling};
      end else if (lim.cell_ceiling >= `DSAR_CELL_FIRST_TOP) begin
         cell_gain_nxt = `DSAR_CELL_TOP_HALF_DB;
      end else begin
         cell_gain_nxt = `DSAR_CELL_TOP_HALF_DB;
         cell_inv_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mic_gain_max_half_db <= `DSAR_CEIL_RST;
         mic_to_silence_cyc <= 32'h0;
         mic_from_silence_cyc <= 32'h0;
         cell_gain_max_half_db <= `DSAR_CELL_TOP_HALF_DB;
         cell_gain_invalid <= 1'b0;
         cell_to_silence_cyc <= 32'h0;
         cell_from_silence_cyc <= 32'h0;
      end else begin
         mic_gain_max_half_db <= mic_gain_nxt;
         mic_to_silence_cyc <= mic_ns_nxt;
         mic_from_silence_cyc <= mic_sn_nxt;
         cell_gain_max_half_db <= cell_gain_nxt;
         cell_gain_invalid <= cell_inv_nxt;
         cell_to_silence_cyc <= cell_ns_nxt;
         cell_from_silence_cyc <= cell_sn_nxt;
      end
   end

   property p_mic_ladder_top;
      @(posedge core_clk) disable iff (!resetn)
      lim.mic_ns == 3'h7 |=> mic_to_silence_cyc == (DEB_UNIT_CYC << 6);
   endproperty
   a_mic_ladder_top: assert property (p_mic_ladder_top) else $error("mic debounce top code wrong");

   property p_mic_sn_zero;
      @(posedge core_clk) disable iff (!resetn)
      lim.mic_sn == 3'h0 |=> mic_from_silence_cyc == 32'h0;
   endproperty
   a_mic_sn_zero: assert property (p_mic_sn_zero) else $error("mic return debounce not zero");

   property p_cell_invalid;
      @(posedge core_clk) disable iff (!resetn)
      (lim.cell_ceiling > `DSAR_CELL_LAST_VALID && lim.cell_ceiling < `DSAR_CELL_FIRST_TOP) |=> cell_gain_invalid;
   endproperty
   a_cell_invalid: assert property (p_cell_invalid) else $error("cell middle code not flagged");

   property p_cell_floor;
      @(posedge core_clk) disable iff (!resetn)
      lim.cell_ceiling == 7'h00 |=> cell_gain_max_half_db == `DSAR_CELL_BASE_HALF_DB && !cell_gain_invalid;
   endproperty
   a_cell_floor: assert property (p_cell_floor) else $error("cell floor gain wrong");
endmodule : dsar_limit_decode
`default_nettype wire

//--- dsar_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsar_host (
   // Clock
   input wire logic core_clk,
   // Register port
   output logic [3:0] reg_page,
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_page = 4'h0;
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end

   // Strobes drop low; page, address and data lines show the inverse of their last value
   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_page <= ~reg_page;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask : idle

   // Callers keep reserved bits zero unless testing refusal
   task automatic wr(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] d);
      @(negedge core_clk);
      reg_page <= pg;
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(negedge core_clk);
      idle();
   endtask : wr

   // Status trusted as no short is ever modelled
   task automatic rd(input logic [3:0] pg, input logic [5:0] ad, output logic [15:0] d);
      int n;
      @(negedge core_clk);
      reg_page <= pg;
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(negedge core_clk);
      idle();
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      d = (n < 4) ? reg_rdata : 16'hXXXX;
   endtask : rd
endmodule : dsar_host
`default_nettype wire

//--- tb_driver_status_agc_limit_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_driver_status_agc_limit_regs;
   localparam int DEB = 4;
   localparam int PS = 20;
   localparam int PL = 50;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] reg_page;
   logic [5:0] reg_addr;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [15:0] reg_wdata, reg_rdata;
   logic [5:0] drv_off = 6'h3F;
   logic pop_start = 1'b0;
   logic pop_sequence_bypass, pop_duration_select, pop_active, cell_gain_invalid;
   logic [6:0] mic_gain_max_half_db;
   logic [7:0] cell_gain_max_half_db;
   logic [31:0] mic_to_silence_cyc, mic_from_silence_cyc, cell_to_silence_cyc, cell_from_silence_cyc;
   logic [6:0] c_code [0:6] = '{7'h00, 7'h01, 7'h44, 7'h45, 7'h5D, 7'h5E, 7'h7F};
   logic [7:0] c_gain [0:6] = '{8'hBB, 8'hBC, 8'hFF, 8'h18, 8'h18, 8'h18, 8'h18};
   logic c_bad [0:6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   always #50 core_clk = ~core_clk;

   dsar_host host (.core_clk(core_clk), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   dsar_regs #(.DEB_UNIT_CYC(DEB), .POP_SHORT_CYC(PS), .POP_LONG_CYC(PL)) DUT (
      .core_clk(core_clk), .resetn(resetn), .reg_page(reg_page), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .speaker_driver_a_off(drv_off[5]), .speaker_driver_b_off(drv_off[4]),
      .handset_receiver_driver_off(drv_off[3]), .virtual_ground_driver_off(drv_off[2]),
      .loudspeaker_driver_off(drv_off[1]), .cellphone_output_driver_off(drv_off[0]),
      .pop_start(pop_start), .pop_sequence_bypass(pop_sequence_bypass),
      .pop_duration_select(pop_duration_select), .pop_active(pop_active),
      .mic_gain_max_half_db(mic_gain_max_half_db), .mic_to_silence_cyc(mic_to_silence_cyc),
      .mic_from_silence_cyc(mic_from_silence_cyc), .cell_gain_max_half_db(cell_gain_max_half_db),
      .cell_gain_invalid(cell_gain_invalid), .cell_to_silence_cyc(cell_to_silence_cyc),
      .cell_from_silence_cyc(cell_from_silence_cyc));

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk_word

   task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk_out

   task automatic rd_chk(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] exp, input string msg);
      logic [15:0] d;
      host.rd(pg, ad, d);
      chk_word(d, exp, msg);
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : settle

   function automatic logic [31:0] deb(input int k);
      return (k == 0) ? 32'h0 : 32'(DEB << (k - 1));
   endfunction : deb

   task automatic t_reset;
      rd_chk(4'h2, 6'h25, 16'hFC00, "status reset");
      rd_chk(4'h2, 6'h26, 16'hFE00, "mic reset");
      rd_chk(4'h2, 6'h27, 16'hFE00, "cell reset");
      chk_out(32'(mic_gain_max_half_db), 32'h7F, "mic ceiling");
      chk_out(32'(cell_gain_max_half_db), 32'h18, "cell ceiling");
      chk_out(32'({pop_sequence_bypass, pop_duration_select}), 32'h0, "pop bits");
      $display("reset test done");
   endtask : t_reset

   task automatic t_flags;
      logic [5:0] pat;
      for (int i = 0; i < 7; i++) begin
         pat = (i < 6) ? ~(6'h01 << i) : 6'h00;
         drv_off = pat;
         settle(3);
         rd_chk(4'h2, 6'h25, {pat, 10'h000}, "live flags");
      end
      drv_off = 6'h3F;
      settle(3);
      $display("flag test done");
   endtask : t_flags

   task automatic t_ctrl;
      host.wr(4'h2, 6'h25, 16'h03FF);
      rd_chk(4'h2, 6'h25, 16'hFC30, "status write");
      chk_out(32'({pop_sequence_bypass, pop_duration_select}), 32'h3, "pop bits set");
      host.wr(4'h2, 6'h25, 16'h0000);
      rd_chk(4'h1, 6'h25, 16'h0000, "wrong page");
      rd_chk(4'h2, 6'h24, 16'h0000, "unmapped");
      host.wr(4'h2, 6'h28, 16'h0000);
      host.wr(4'h3, 6'h26, 16'h0000);
      rd_chk(4'h2, 6'h26, 16'hFE00, "stray write");
      host.wr(4'h2, 6'h26, 16'h0000);
      @(negedge core_clk);
      resetn = 1'b0;
      settle(2);
      resetn = 1'b1;
      rd_chk(4'h2, 6'h26, 16'hFE00, "second reset");
      $display("control test done");
   endtask : t_ctrl

   task automatic t_mic;
      host.wr(4'h2, 6'h26, 16'hFFFF);
      rd_chk(4'h2, 6'h26, 16'hFFF8, "mic all ones");
      for (int k = 0; k < 8; k++) begin
         host.wr(4'h2, 6'h26, {7'(k * 9), 3'(k), 3'(7 - k), 3'h0});
         settle(2);
         chk_out(32'(mic_gain_max_half_db), 32'(k * 9), "mic ceiling");
         chk_out(mic_to_silence_cyc, deb(k), "mic to silence");
         chk_out(mic_from_silence_cyc, deb(7 - k), "mic from silence");
      end
      $display("mic test done");
   endtask : t_mic

   task automatic t_cell;
      for (int i = 0; i < 7; i++) begin
         host.wr(4'h2, 6'h27, {c_code[i], 9'h1FF});
         settle(2);
         rd_chk(4'h2, 6'h27, {c_code[i], 9'h000}, "cell word");
         chk_out(32'(cell_gain_max_half_db), 32'(c_gain[i]), "cell ceiling");
         chk_out(32'(cell_gain_invalid), 32'(c_bad[i]), "cell invalid");
         chk_out(cell_to_silence_cyc | cell_from_silence_cyc, 32'h0, "cell debounce");
      end
      $display("cell test done");
   endtask : t_cell

   task automatic pop_run(input logic [15:0] ctrl, input int exp);
      int n;
      host.wr(4'h2, 6'h25, ctrl);
      pop_start = 1'b1;
      @(negedge core_clk);
      pop_start = 1'b0;
      n = 0;
      while (pop_active === 1'b1 && n < 200) begin
         n++;
         @(negedge core_clk);
      end
      chk_out(32'(n), 32'(exp), "pop length");
   endtask : pop_run

   task automatic t_pop;
      pop_run(16'h0000, PS);
      pop_run(16'h0010, PL);
      // Bypass set mid-run must end the sequence early
      host.wr(4'h2, 6'h25, 16'h0000);
      pop_start = 1'b1;
      @(negedge core_clk);
      pop_start = 1'b0;
      settle(8);
      host.wr(4'h2, 6'h25, 16'h0020);
      chk_out(32'(pop_active), 32'h1, "pop still running");
      settle(1);
      chk_out(32'(pop_active), 32'h0, "pop cut by bypass");
      pop_run(16'h0020, 0);
      $display("pop test done");
   endtask : t_pop

   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // Whole run needs about 250 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      settle(12);
      resetn = 1'b1;
      t_reset();
      t_flags();
      t_ctrl();
      t_mic();
      t_cell();
      t_pop();
      finish_test();
   end
endmodule : tb_driver_status_agc_limit_regs
`default_nettype wire
